// *** logic/sadc_ctrl.sv ***
`timescale 1ns/100ps
`include "sadc_defines.svh"

module sadc_ctrl import sadc_pkg::*; #(
  parameter int unsigned DIV = `SADC_CLK_DIV,
  parameter int unsigned SETUP_TICKS = `SADC_SETUP_TICKS,
  parameter int unsigned BIT_TICKS = `SADC_BIT_TICKS
) (
  input wire logic core_clk_in,              // oscillator clock, 8 MHz
  input wire logic rst_in,                   // async reset, active high
  input wire logic [7:0] reg_addr_in,        // register address
  input wire logic [7:0] reg_wdata_in,       // register write data
  input wire logic reg_wr_in,                // write strobe
  input wire logic reg_rd_in,                // read strobe
  output logic [7:0] reg_rdata_out,          // read data, cycle after the strobe
  input wire logic wait_entered_in,          // processor is in wait mode
  input wire logic cmp_above_in,             // comparator: input at or above dac code
  output logic [7:0] dac_code_out,           // trial code to the dac
  output logic converter_power_on_out,       // analog power enable
  output logic conv_busy_out,                // a conversion is armed or running
  output logic irq_out                       // level interrupt, vector four line
);

  localparam int CONV_CYC = int'((SETUP_TICKS + `SADC_RES_BITS * BIT_TICKS) * DIV);

  sadc_bus_t bus;
  assign bus = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  // register decode
  wire wr_ctrl = bus.wr && (bus.addr == `SADC_OFS_CTRL);
  wire wr_opt = bus.wr && (bus.addr == `SADC_OFS_OPTION);
  wire wr_clr = bus.wr && (bus.addr == `SADC_OFS_IRQ_CLR);
  wire wr_ien = bus.wr && (bus.addr == `SADC_OFS_IRQ_EN);

  // state
  sadc_state_t state_q;
  sadc_state_t state_d;
  logic done_irq_enable_q;
  logic converter_power_on_q;
  logic done_q;
  logic wait_sync_q;
  logic [7:0] result_q;
  logic [7:0] sar_q;
  logic [2:0] tick_cnt_q;
  logic [2:0] bit_idx_q;
  logic [`SADC_EVT_BITS-1:0] irq_sts_q;
  logic [`SADC_EVT_BITS-1:0] irq_ien_q;
  logic [7:0] rdata_q;
  logic conv_tick;

  // the power bit written together with the begin bit governs the start
  wire begin_conversion_bit = wr_ctrl && bus.wdata[`SADC_BIT_BEGIN];
  wire start_go = begin_conversion_bit && bus.wdata[`SADC_BIT_POWER];
  wire kill = wr_ctrl && !bus.wdata[`SADC_BIT_POWER];
  wire busy = (state_q != SADC_IDLE);
  wire restart = start_go && busy;
  wire running = (state_q == SADC_SETUP) || (state_q == SADC_BITS);
  wire sync_go = (state_q == SADC_SYNC) && wait_entered_in && !start_go && !kill;
  wire div_clr = start_go || sync_go;
  wire div_en = converter_power_on_q && running;
  wire setup_end = (state_q == SADC_SETUP) && conv_tick
    && (tick_cnt_q == 3'(SETUP_TICKS - 1));
  wire bit_end = (state_q == SADC_BITS) && conv_tick && (tick_cnt_q == 3'(BIT_TICKS - 1));
  wire last_bit = (bit_idx_q == 3'd0);
  wire done_evt = bit_end && last_bit && !start_go && !kill;
  wire [7:0] bit_mask = 8'h01 << bit_idx_q;
  wire [7:0] next_mask = 8'h01 << (bit_idx_q - 3'd1);
  // keep the trial bit only if the input is at or above the trial level
  wire [7:0] sar_final = cmp_above_in ? sar_q : (sar_q & ~bit_mask);
  wire [`SADC_EVT_BITS-1:0] evt_set = {restart, done_evt};

  // read path
  sadc_ctrl_t ctrl_rd;
  assign ctrl_rd = '{
    irq_en: done_irq_enable_q,
    done: done_q,
    begin_conv: 1'b0,
    power: converter_power_on_q,
    unused: 4'h0
  };
  wire [7:0] opt_rd = {7'h00, wait_sync_q};
  wire [7:0] sts_rd = {{(8 - `SADC_EVT_BITS){1'b0}}, irq_sts_q};
  wire [7:0] ien_rd = {{(8 - `SADC_EVT_BITS){1'b0}}, irq_ien_q};
  wire [7:0] rdata_d =
    (bus.addr == `SADC_OFS_RESULT) ? result_q :
    (bus.addr == `SADC_OFS_CTRL) ? ctrl_rd :
    (bus.addr == `SADC_OFS_OPTION) ? opt_rd :
    (bus.addr == `SADC_OFS_IRQ_STS) ? sts_rd :
    (bus.addr == `SADC_OFS_IRQ_EN) ? ien_rd : 8'h00;

  sadc_tick_div #(
    .DIV(DIV)
  ) u_div (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .enable_in(div_en),
    .clear_in(div_clr),
    .tick_out(conv_tick)
  );

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      SADC_IDLE: begin
        state_d = SADC_IDLE;
      end
      SADC_SYNC: begin
        if (wait_entered_in) begin
          state_d = SADC_SETUP;
        end
      end
      SADC_SETUP: begin
        if (setup_end) begin
          state_d = SADC_BITS;
        end
      end
      SADC_BITS: begin
        if (bit_end && last_bit) begin
          state_d = SADC_IDLE;
        end
      end
      default: begin
        state_d = SADC_IDLE;
      end
    endcase
    if (start_go) begin
      state_d = wait_sync_q ? SADC_SYNC : SADC_SETUP;
    end else if (kill) begin
      state_d = SADC_IDLE;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= SADC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_q <= 3'd0;
    end else if (div_clr || setup_end || bit_end) begin
      tick_cnt_q <= 3'd0;
    end else if (conv_tick) begin
      tick_cnt_q <= tick_cnt_q + 3'd1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_idx_q <= 3'd7;
      sar_q <= 8'h00;
    end else if (start_go) begin
      bit_idx_q <= 3'd7;
      sar_q <= 8'h00;
    end else if (setup_end) begin
      sar_q <= 8'h80;
    end else if (bit_end) begin
      bit_idx_q <= bit_idx_q - 3'd1;
      sar_q <= last_bit ? sar_final : (sar_final | next_mask);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_q <= 8'h00;
    end else if (done_evt) begin
      result_q <= sar_final;
    end
  end

  // a start in the finishing cycle abandons that conversion, so no done is set
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'(`SADC_CTRL_RESET >> `SADC_BIT_DONE);
    end else if (done_evt) begin
      done_q <= 1'b1;
    end else if (start_go) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_irq_enable_q <= 1'b0;
      converter_power_on_q <= 1'b0;
      wait_sync_q <= 1'b0;
      irq_ien_q <= '0;
    end else begin
      if (wr_ctrl) begin
        done_irq_enable_q <= bus.wdata[`SADC_BIT_IRQ_EN];
        converter_power_on_q <= bus.wdata[`SADC_BIT_POWER];
      end
      if (wr_opt) begin
        wait_sync_q <= bus.wdata[`SADC_OPT_WAIT_SYNC];
      end
      if (wr_ien) begin
        irq_ien_q <= bus.wdata[`SADC_EVT_BITS-1:0];
      end
    end
  end

  // sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= evt_set | (irq_sts_q & ~(wr_clr ? bus.wdata[`SADC_EVT_BITS-1:0] : '0));
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus.rd ? rdata_d : 8'h00;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign dac_code_out = sar_q;
  assign converter_power_on_out = converter_power_on_q;
  assign conv_busy_out = busy;
  assign irq_out = (done_q && done_irq_enable_q) || (|(irq_sts_q & irq_ien_q));

  // assertion helpers: cycles since the last tick and since the real start
  logic [15:0] gap_q;
  logic [15:0] run_q;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_q <= 16'h0000;
      run_q <= 16'h0000;
    end else begin
      gap_q <= (div_clr || conv_tick) ? 16'h0000 : gap_q + 16'h0001;
      run_q <= div_clr ? 16'h0001 : run_q + 16'h0001;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_direct_launch;
    start_go && !wait_sync_q ##1 state_q == SADC_SETUP && tick_cnt_q == 3'd0;
  endsequence

  sequence s_sync_armed;
    start_go && wait_sync_q ##1 state_q == SADC_SYNC;
  endsequence

  AST_TICK_DIV: assert property (conv_tick |-> gap_q == 16'(DIV - 1))
    else $error("conversion tick spacing is not the divide factor");

  AST_RESULT_LOAD: assert property (done_evt |=> result_q == $past(sar_final))
    else $error("result register missed the finished code");

  AST_START_CLEARS_DONE: assert property (start_go && !done_evt |=> !done_q)
    else $error("start did not clear the done flag");

  AST_DONE_SETS: assert property (done_evt |=> done_q && state_q == SADC_IDLE)
    else $error("finished conversion did not set the done flag");

  AST_ONE_SHOT: assert property (state_q == SADC_IDLE && !start_go |=> state_q == SADC_IDLE)
    else $error("converter left idle without a start");

  AST_RESTART: assert property (restart && !wait_sync_q |-> s_direct_launch)
    else $error("restart did not relaunch the conversion");

  AST_BEGIN_READS_ZERO: assert property (bus.rd && bus.addr == `SADC_OFS_CTRL
    |=> reg_rdata_out[`SADC_BIT_BEGIN] == 1'b0)
    else $error("begin bit read back as one");

  AST_IRQ_LEVEL: assert property (done_q && done_irq_enable_q |-> irq_out)
    else $error("enabled done flag did not raise the interrupt");

  AST_IRQ_MASK: assert property (!done_irq_enable_q && irq_sts_q == '0 |-> !irq_out)
    else $error("interrupt raised while masked");

  AST_POWER_DOWN: assert property (kill |=> !converter_power_on_out && state_q == SADC_IDLE)
    else $error("clearing power did not stop the converter");

  AST_WAIT_KEEPS_POWER: assert property (wait_entered_in && !wr_ctrl
    |=> converter_power_on_out == $past(converter_power_on_out))
    else $error("wait mode changed the converter power");

  AST_RESET_VALUE: assert property ($fell(rst_in) |-> ctrl_rd == `SADC_CTRL_RESET
    && state_q == SADC_IDLE)
    else $error("control register not at its reset value");

  AST_SYNC_HOLD: assert property (s_sync_armed ##0 (!wait_entered_in && !wr_ctrl)
    |=> state_q == SADC_SYNC && sar_q == 8'h00)
    else $error("synchronised start began before wait mode");

  AST_CONV_LENGTH: assert property (done_evt |-> run_q == 16'(CONV_CYC))
    else $error("conversion length differs from the tick budget");

  AST_DONE_READ_ONLY: assert property (wr_ctrl && !start_go && !done_evt
    |=> done_q == $past(done_q))
    else $error("write changed the done flag");

  AST_LOW_BITS_ZERO: assert property (bus.rd && bus.addr == `SADC_OFS_CTRL
    |=> reg_rdata_out[3:0] == 4'h0)
    else $error("unused control bits read nonzero");

  // armed release, first trial code, event flags and quiet outputs after reset
  AST_SYNC_START: assert property (sync_go
    |=> state_q == SADC_SETUP && tick_cnt_q == 3'd0)
    else $error("wait mode did not release the armed conversion");

  AST_FIRST_TRIAL: assert property (setup_end && !start_go |=> dac_code_out == 8'h80)
    else $error("first trial code is not the top bit");

  AST_RESTART_FLAG: assert property (restart |=> irq_sts_q[`SADC_EVT_RESTART])
    else $error("abandoned conversion left no restart event");

  AST_DONE_FLAG: assert property (done_evt |=> irq_sts_q[`SADC_EVT_DONE])
    else $error("finished conversion left no done event");

  AST_UNPOWERED_IDLE: assert property (!converter_power_on_out |-> !conv_busy_out)
    else $error("converter busy while powered down");

  AST_RESET_QUIET: assert property ($fell(rst_in)
    |-> !irq_out && !conv_busy_out && dac_code_out == 8'h00 && reg_rdata_out == 8'h00)
    else $error("outputs not quiet after reset");

endmodule

// *** logic/sadc_defines.svh ***
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// register offsets on the 8-bit register port
`define SADC_OFS_RESULT 8'hd0
`define SADC_OFS_CTRL 8'hd1
`define SADC_OFS_OPTION 8'he0
`define SADC_OFS_IRQ_STS 8'he1
`define SADC_OFS_IRQ_CLR 8'he2
`define SADC_OFS_IRQ_EN 8'he3

// converter_control_reg field positions
`define SADC_BIT_IRQ_EN 7
`define SADC_BIT_DONE 6
`define SADC_BIT_BEGIN 5
`define SADC_BIT_POWER 4
`define SADC_CTRL_RESET 8'h40

// option and event bit positions
`define SADC_OPT_WAIT_SYNC 0
`define SADC_EVT_DONE 0
`define SADC_EVT_RESTART 1
`define SADC_EVT_BITS 2

// timing: conversion time at the reference oscillator, counted in divided ticks
`define SADC_CLK_DIV 12
`define SADC_REF_OSC_KHZ 8000
`define SADC_CONV_TIME_NS 70000
`define SADC_CONV_TICKS ((`SADC_CONV_TIME_NS * `SADC_REF_OSC_KHZ / 1000000) / `SADC_CLK_DIV)
`define SADC_RES_BITS 8
`define SADC_BIT_TICKS 5
`define SADC_SETUP_TICKS (`SADC_CONV_TICKS - `SADC_RES_BITS * `SADC_BIT_TICKS)

`endif

// *** logic/sadc_pkg.sv ***
package sadc_pkg;

  typedef enum logic [3:0] {
    SADC_IDLE  = 4'b0001,
    SADC_SYNC  = 4'b0010,
    SADC_SETUP = 4'b0100,
    SADC_BITS  = 4'b1000
  } sadc_state_t;

  typedef struct packed {
    logic irq_en;
    logic done;
    logic begin_conv;
    logic power;
    logic [3:0] unused;
  } sadc_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sadc_bus_t;

endpackage

// *** logic/sadc_tick_div.sv ***
`timescale 1ns/100ps
`include "sadc_defines.svh"

module sadc_tick_div #(
  parameter int unsigned DIV = `SADC_CLK_DIV
) (
  input wire logic core_clk_in, // oscillator clock
  input wire logic rst_in,      // async reset, active high
  input wire logic enable_in,   // count while high
  input wire logic clear_in,    // restart the phase
  output logic tick_out         // one-cycle pulse every DIV cycles
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire last_w = (cnt_q == CW'(DIV - 1));

  assign cnt_d = (clear_in || !enable_in || last_w) ? '0 : cnt_q + 1'b1;
  assign tick_out = enable_in && !clear_in && last_w;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// *** testbench/sadc_analog_model.sv ***
`timescale 1ns/100ps

module sadc_analog_model (
  input wire logic core_clk_in,    // oscillator clock
  input wire logic [7:0] level_in, // voltage on the one selected input line
  input wire logic [7:0] dac_in,   // trial code from the converter
  input wire logic power_in,       // analog power enable
  output logic cmp_above_out       // input at or above trial code
);
  logic junk_q = 1'b0;
  // an unpowered comparator gives no stable answer
  always @(posedge core_clk_in) begin
    junk_q <= ~junk_q;
  end
  // one analog source only
  assign cmp_above_out = power_in ? (level_in >= dac_in) : junk_q;
endmodule

// *** testbench/sadc_tb.sv ***
`timescale 1ns/100ps
`include "sadc_defines.svh"

module tb;
  localparam int DIV = 2;
  localparam int CONV = (`SADC_SETUP_TICKS + `SADC_RES_BITS * `SADC_BIT_TICKS) * DIV;
  logic core_clk_in, rst_in, reg_wr_in, reg_rd_in, wait_entered_in, cmp_above_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, dac_code_out, level;
  logic converter_power_on_out, conv_busy_out, irq_out;
  logic [7:0] lv [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
  int failures = 0;
  int checks_done = 0;
  int n;

  sadc_ctrl #(.DIV(DIV)) dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .wait_entered_in(wait_entered_in),
    .cmp_above_in(cmp_above_in), .dac_code_out(dac_code_out),
    .converter_power_on_out(converter_power_on_out), .conv_busy_out(conv_busy_out),
    .irq_out(irq_out));

  sadc_analog_model ana_u (.core_clk_in(core_clk_in), .level_in(level), .dac_in(dac_code_out),
    .power_in(converter_power_on_out), .cmp_above_out(cmp_above_in));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp, "read data");
  endtask

  // counts cycles until the sequencer goes idle and checks the span
  task wait_idle(input int lo, input int hi);
    n = 0;
    #1;
    while (conv_busy_out !== 1'b0 && n < 2000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    chk((n >= lo && n <= hi) ? 8'h01 : 8'h00, 8'h01, "conversion cycles");
  endtask

  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    wait_entered_in = 1'b0;
    level = 8'h00;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    chk({7'h00, irq_out}, 8'h00, "irq after reset");
    rd(`SADC_OFS_CTRL, 8'h40);
    rd(`SADC_OFS_RESULT, 8'h00);
    rd(8'h55, 8'h00);
    $display("test reset done");
    // power goes on two cycles before the first start
    wr(`SADC_OFS_CTRL, 8'h10);
    #1;
    chk({7'h00, converter_power_on_out}, 8'h01, "power");
    for (int i = 0; i < 4; i++) begin
      level = lv[i];
      wr(`SADC_OFS_CTRL, 8'h30);
      wait_idle(CONV - 2, CONV + 2);
      rd(`SADC_OFS_CTRL, 8'h50);
      rd(`SADC_OFS_RESULT, lv[i]);
      chk(dac_code_out, lv[i], "final trial code");
    end
    wr(`SADC_OFS_RESULT, 8'h33);
    rd(`SADC_OFS_RESULT, 8'h5a);
    repeat (150) @(posedge core_clk_in);
    #1;
    chk({7'h00, conv_busy_out}, 8'h00, "no second run");
    $display("test conversion done");
    wr(`SADC_OFS_IRQ_CLR, 8'h03);
    level = 8'h3c;
    wr(`SADC_OFS_CTRL, 8'h30);
    repeat (30) @(posedge core_clk_in);
    rd(`SADC_OFS_CTRL, 8'h10);
    wr(`SADC_OFS_CTRL, 8'h30);
    wait_idle(CONV - 2, CONV + 2);
    rd(`SADC_OFS_IRQ_STS, 8'h03);
    rd(`SADC_OFS_RESULT, 8'h3c);
    wr(`SADC_OFS_CTRL, 8'h30);
    wr(`SADC_OFS_CTRL, 8'h5f);
    rd(`SADC_OFS_CTRL, 8'h10);
    wait_idle(CONV - 4, CONV + 2);
    $display("test restart done");
    wr(`SADC_OFS_IRQ_CLR, 8'h03);
    wr(`SADC_OFS_CTRL, 8'hb0);
    #1;
    chk({7'h00, irq_out}, 8'h00, "irq while running");
    wait_idle(CONV - 2, CONV + 2);
    @(posedge core_clk_in);
    #1;
    chk({7'h00, irq_out}, 8'h01, "irq at done");
    rd(`SADC_OFS_CTRL, 8'hd0);
    wr(`SADC_OFS_CTRL, 8'h10);
    #1;
    chk({7'h00, irq_out}, 8'h00, "irq masked");
    wr(`SADC_OFS_IRQ_EN, 8'h01);
    #1;
    chk({7'h00, irq_out}, 8'h01, "status irq");
    rd(`SADC_OFS_IRQ_EN, 8'h01);
    wr(`SADC_OFS_IRQ_CLR, 8'h03);
    #1;
    chk({7'h00, irq_out}, 8'h00, "irq cleared");
    rd(`SADC_OFS_IRQ_STS, 8'h00);
    wr(`SADC_OFS_IRQ_EN, 8'h00);
    $display("test interrupt done");
    wait_entered_in <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    #1;
    chk({7'h00, converter_power_on_out}, 8'h01, "power in wait");
    @(posedge core_clk_in);
    wait_entered_in <= 1'b0;
    wr(`SADC_OFS_CTRL, 8'h30);
    repeat (20) @(posedge core_clk_in);
    wr(`SADC_OFS_CTRL, 8'h00);
    @(posedge core_clk_in);
    #1;
    chk({6'h00, converter_power_on_out, conv_busy_out}, 8'h00, "power down");
    rd(`SADC_OFS_CTRL, 8'h00);
    $display("test power done");
    wr(`SADC_OFS_CTRL, 8'h10);
    wr(`SADC_OFS_OPTION, 8'h01);
    level = 8'h81;
    wr(`SADC_OFS_CTRL, 8'h30);
    repeat (150) @(posedge core_clk_in);
    #1;
    chk({7'h00, conv_busy_out}, 8'h01, "held for wait");
    rd(`SADC_OFS_CTRL, 8'h10);
    chk(dac_code_out, 8'h00, "no trial before wait");
    @(posedge core_clk_in);
    wait_entered_in <= 1'b1;
    @(posedge core_clk_in);
    wait_idle(CONV - 2, CONV + 3);
    rd(`SADC_OFS_RESULT, 8'h81);
    @(posedge core_clk_in);
    wait_entered_in <= 1'b0;
    level = 8'h42;
    wr(`SADC_OFS_CTRL, 8'h30);
    wait_entered_in <= 1'b1;
    wait_idle(CONV - 1, CONV + 3);
    rd(`SADC_OFS_RESULT, 8'h42);
    @(posedge core_clk_in);
    wait_entered_in <= 1'b0;
    wr(`SADC_OFS_OPTION, 8'h00);
    $display("test wait sync done");
    wr(`SADC_OFS_CTRL, 8'h30);
    repeat (30) @(posedge core_clk_in);
    rst_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    chk({6'h00, converter_power_on_out, conv_busy_out}, 8'h00, "stopped");
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(`SADC_OFS_CTRL, 8'h40);
    $display("test reset in run done");
    end_sim();
  end
endmodule
